// [verilog/strap_cfg_pkg.sv]
package strap_cfg_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int CAPTURE_DELAY_MS = 2;
	localparam int CAPTURE_CYCLES = CAPTURE_DELAY_MS * (CLK_HZ / 1000);
	localparam int CNT_W = 24;

	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;

	// control fields
	localparam int CTRL_PUSH_PULL_BIT = 0;
	localparam int CTRL_WL_PD_OFF_BIT = 1;
	localparam int CTRL_BT_PD_OFF_BIT = 2;
	localparam int CTRL_WAKE_PULL_LSB = 3;
	localparam int CTRL_OTP_USE_BIT = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;

	// status fields
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_STRAP_LSB = 1;
	localparam int STAT_MODE_LSB = 4;
	localparam int STAT_JTAG_BIT = 6;
	localparam int STAT_OTP_ON_BIT = 7;
	localparam int STAT_OTP_SRC_BIT = 8;
	localparam int STAT_WAKE_BIT = 9;

	// wake pull selection
	localparam logic [1:0] WAKE_PULL_NONE = 2'h0;
	localparam logic [1:0] WAKE_PULL_DOWN = 2'h1;
	localparam logic [1:0] WAKE_PULL_UP = 2'h2;

	// power states
	localparam logic [1:0] PWR_ACTIVE = 2'h0;
	localparam logic [1:0] PWR_SLEEP = 2'h1;
	localparam logic [1:0] PWR_DOWN = 2'h2;
	localparam logic [1:0] PWR_OUT_OF_RESET = 2'h3;

	// host interface strap codes and modes
	localparam logic [2:0] STRAP_RESET = 3'h0;
	localparam logic [2:0] STRAP_HSIC = 3'h6;
	localparam logic [2:0] STRAP_HSIC_NO_BOOT = 3'h7;

	typedef enum logic [1:0] {
		HOST_NONE = 2'b00,
		HOST_SDIO = 2'b01,
		HOST_HSIC = 2'b10,
		HOST_HSIC_NO_BOOT = 2'b11
	} host_mode_t;

	typedef enum logic [1:0] {
		CAP_HOLD = 2'b00,
		CAP_WAIT = 2'b01,
		CAP_DONE = 2'b10
	} cap_state_t;
endpackage : strap_cfg_pkg

// [verilog/sync_two_ff.sv]
`timescale 1ns/1ps
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// async in, synced out
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
		end
	end

	assign syncOut = stage2_r;
endmodule : sync_two_ff

// [verilog/wlan_strap_config.sv]
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - capture all strap levels, pick modes; the code latches only hostIfcStrap, debug select is followed live
// - capture some milliseconds after reset release
// - after capture, straps become normal pins
// - decode 0XX SDIO, 110 HSIC, 111 no-boot
// - internal pulls default; board overrides strongly
// - debug select high routes GPIOs to JTAG
// - debug select pulled down means plain GPIO
// - unselected host interface is tristated
// - HSIC selected: SDIO lines get pulls; the code turns them off in power-down
// - no keeper on idle HSIC lines
// - OTP enable picks OTP or default sources
// - clock request: active high, drive type, pulled low
// - regulator-enable pull-down, software may disable
// - device wake pull programmable, reset pulled down
module wlan_strap_config #(
	parameter int CAPTURE_DELAY = strap_cfg_pkg::CAPTURE_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// pins seen from the board
	input wire logic extResetN,
	input wire logic [2:0] hostIfcStrap,
	input wire logic debugPortSelect,
	input wire logic deviceWakeIn,
	// power management and otp, same clock
	input wire logic [1:0] powerState,
	input wire logic otpProgrammed,
	input wire logic clockRequest,
	// register port
	input wire logic [strap_cfg_pkg::ADDR_W-1:0] regAddr,
	input wire logic [strap_cfg_pkg::DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [strap_cfg_pkg::DATA_W-1:0] regRdata,
	// strap pin ownership and pulls
	output logic strapPinsFunctional,
	output logic strapPullEnable,
	output logic debugSelPullDown,
	output logic jtagRouteEnable,
	// host interface control
	output logic [1:0] hostMode,
	output logic hostModeUndefined,
	output logic sdioTristate,
	output logic hsicTristate,
	output logic sdioPullEnable,
	output logic hsicKeeperEnable,
	// otp and id sources
	output logic otpPowerOn,
	output logic cardInfoFromOtp,
	output logic chipIdFromOtp,
	// clock request pin
	output logic clockRequestOut,
	output logic clockRequestOutEnN,
	output logic clockRequestPullDown,
	// regulator enable pulls
	output logic wirelessRegPullDown,
	output logic bluetoothRegPullDown,
	// device wake pin
	output logic deviceWakeInputEnable,
	output logic deviceWakePullUp,
	output logic deviceWakePullDown
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		strap_cfg_pkg::cap_state_t state;
		logic [strap_cfg_pkg::CNT_W-1:0] count;
		logic [2:0] strap;
		logic [5:0] ctrl;
		logic [strap_cfg_pkg::DATA_W-1:0] rdata;
	} regs_t;

	localparam regs_t REGS_RESET = '{
		state: strap_cfg_pkg::CAP_HOLD,
		count: '0,
		strap: strap_cfg_pkg::STRAP_RESET,
		ctrl: strap_cfg_pkg::CTRL_RESET,
		rdata: '0
	};
	localparam logic [strap_cfg_pkg::CNT_W-1:0] COUNT_LAST =
		CAPTURE_DELAY[strap_cfg_pkg::CNT_W-1:0] - 1'b1;

	regs_t s_r;
	regs_t s_nxt;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [5:0] pinSync;
	logic extResetSyncN;
	logic [2:0] strapSync;
	logic debugSelSync;
	logic wakeSync;

	sync_two_ff #(.WIDTH(6)) u_pin_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.asyncIn({deviceWakeIn, debugPortSelect, hostIfcStrap, extResetN}),
		.syncOut(pinSync)
	);

	assign extResetSyncN = pinSync[0];
	assign strapSync = pinSync[3:1];
	assign debugSelSync = pinSync[4];
	assign wakeSync = pinSync[5];

	// ****************************************
	// decode
	// ****************************************
	logic captured;
	logic isHsic;
	logic powerDown;
	logic outOfReset;
	logic otpUse;
	logic [1:0] wakePull;
	logic [strap_cfg_pkg::DATA_W-1:0] statusWord;

	assign captured = (s_r.state == strap_cfg_pkg::CAP_DONE);
	assign powerDown = (powerState == strap_cfg_pkg::PWR_DOWN);
	assign outOfReset = (powerState == strap_cfg_pkg::PWR_OUT_OF_RESET);
	assign otpUse = s_r.ctrl[strap_cfg_pkg::CTRL_OTP_USE_BIT];
	assign wakePull = s_r.ctrl[strap_cfg_pkg::CTRL_WAKE_PULL_LSB +: 2];

	always_comb begin
		hostMode = strap_cfg_pkg::HOST_NONE;
		hostModeUndefined = 1'b0;
		if (captured) begin
			if (!s_r.strap[2]) begin
				hostMode = strap_cfg_pkg::HOST_SDIO;
			end else if (s_r.strap == strap_cfg_pkg::STRAP_HSIC) begin
				hostMode = strap_cfg_pkg::HOST_HSIC;
			end else if (s_r.strap == strap_cfg_pkg::STRAP_HSIC_NO_BOOT) begin
				hostMode = strap_cfg_pkg::HOST_HSIC_NO_BOOT;
			end else begin
				// 10x has no meaning; park both interfaces rather than guess
				hostModeUndefined = 1'b1;
			end
		end
	end

	assign isHsic = hostMode[1];
	assign sdioTristate = (hostMode != strap_cfg_pkg::HOST_SDIO);
	assign hsicTristate = !isHsic;
	assign sdioPullEnable = isHsic && !powerDown;
	assign hsicKeeperEnable = 1'b0;

	// straps stay inputs with their own pulls until sampled
	assign strapPinsFunctional = captured;
	assign strapPullEnable = !captured;
	assign debugSelPullDown = 1'b1;
	assign jtagRouteEnable = debugSelSync;

	assign otpPowerOn = otpUse;
	assign cardInfoFromOtp = otpUse && otpProgrammed;
	assign chipIdFromOtp = otpUse && otpProgrammed;

	// ****************************************
	// pad control
	// ****************************************
	always_comb begin
		clockRequestOut = 1'b0;
		clockRequestOutEnN = 1'b1;
		clockRequestPullDown = 1'b0;
		if (powerDown) begin
			clockRequestPullDown = 1'b1;
		end else if (s_r.ctrl[strap_cfg_pkg::CTRL_PUSH_PULL_BIT] && !outOfReset) begin
			clockRequestOut = clockRequest;
			clockRequestOutEnN = 1'b0;
		end else begin
			// open drain: only the low level is driven
			clockRequestOut = 1'b0;
			clockRequestOutEnN = clockRequest;
		end
	end

	// software may drop the pull-downs only while the rails are up and running
	assign wirelessRegPullDown = powerDown || outOfReset ||
		!s_r.ctrl[strap_cfg_pkg::CTRL_WL_PD_OFF_BIT];
	assign bluetoothRegPullDown = powerDown || outOfReset ||
		!s_r.ctrl[strap_cfg_pkg::CTRL_BT_PD_OFF_BIT];

	always_comb begin
		deviceWakeInputEnable = !powerDown;
		deviceWakePullUp = 1'b0;
		deviceWakePullDown = 1'b0;
		if (outOfReset) begin
			deviceWakePullDown = 1'b1;
		end else if (!powerDown) begin
			deviceWakePullUp = (wakePull == strap_cfg_pkg::WAKE_PULL_UP);
			deviceWakePullDown = (wakePull == strap_cfg_pkg::WAKE_PULL_DOWN);
		end
	end

	// ****************************************
	// status word
	// ****************************************
	always_comb begin
		statusWord = '0;
		statusWord[strap_cfg_pkg::STAT_DONE_BIT] = captured;
		statusWord[strap_cfg_pkg::STAT_STRAP_LSB +: 3] = s_r.strap;
		statusWord[strap_cfg_pkg::STAT_MODE_LSB +: 2] = hostMode;
		statusWord[strap_cfg_pkg::STAT_JTAG_BIT] = debugSelSync;
		statusWord[strap_cfg_pkg::STAT_OTP_ON_BIT] = otpUse;
		statusWord[strap_cfg_pkg::STAT_OTP_SRC_BIT] = cardInfoFromOtp;
		statusWord[strap_cfg_pkg::STAT_WAKE_BIT] = wakeSync;
	end

	// ****************************************
	// capture sequencer and registers
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = '0;
		unique case (s_r.state)
			strap_cfg_pkg::CAP_HOLD: begin
				s_nxt.count = '0;
				if (extResetSyncN) begin
					s_nxt.state = strap_cfg_pkg::CAP_WAIT;
				end
			end
			strap_cfg_pkg::CAP_WAIT: begin
				if (!extResetSyncN) begin
					s_nxt.state = strap_cfg_pkg::CAP_HOLD;
				end else if (s_r.count == COUNT_LAST) begin
					s_nxt.state = strap_cfg_pkg::CAP_DONE;
					s_nxt.strap = strapSync;
				end else begin
					s_nxt.count = s_r.count + 1'b1;
				end
			end
			strap_cfg_pkg::CAP_DONE: begin
				// a fresh external reset is a new power-on: sample again
				if (!extResetSyncN) begin
					s_nxt.state = strap_cfg_pkg::CAP_HOLD;
				end
			end
			default: begin
				s_nxt.state = strap_cfg_pkg::CAP_HOLD;
			end
		endcase
		if (regWrite && regAddr == strap_cfg_pkg::CTRL_OFFSET) begin
			s_nxt.ctrl = regWdata[5:0];
		end
		if (regRead) begin
			if (regAddr == strap_cfg_pkg::CTRL_OFFSET) begin
				s_nxt.rdata = {26'h0, s_r.ctrl};
			end else if (regAddr == strap_cfg_pkg::STATUS_OFFSET) begin
				s_nxt.rdata = statusWord;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_r <= REGS_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign regRdata = s_r.rdata;

	// ****************************************
	// checks
	// ****************************************
	sequence s_waitEnd;
		s_r.state == strap_cfg_pkg::CAP_WAIT && s_r.count == COUNT_LAST && extResetSyncN;
	endsequence
	sequence s_doneNext;
		##1 captured && s_r.strap == $past(strapSync);
	endsequence
	property p_capture;
		@(posedge mclk) disable iff (!rst_n) s_waitEnd |-> s_doneNext;
	endproperty
	a_capture: assert property (p_capture) else $error("straps not captured");
	property p_delay;
		@(posedge mclk) disable iff (!rst_n)
			$rose(captured) |-> $past(s_r.count) == COUNT_LAST;
	endproperty
	a_delay: assert property (p_delay) else $error("capture came early");
	property p_pinsFree;
		@(posedge mclk) disable iff (!rst_n) strapPinsFunctional == captured && strapPullEnable != captured;
	endproperty
	a_pinsFree: assert property (p_pinsFree) else $error("strap pins not released");
	property p_decode;
		@(posedge mclk) disable iff (!rst_n)
			captured |-> (s_r.strap[2] == 1'b0) == (hostMode == strap_cfg_pkg::HOST_SDIO)
			&& (s_r.strap == 3'h7) == (hostMode == strap_cfg_pkg::HOST_HSIC_NO_BOOT);
	endproperty
	a_decode: assert property (p_decode) else $error("host mode decode wrong");
	property p_jtag;
		@(posedge mclk) disable iff (!rst_n)
			$rose(debugPortSelect) ##1 debugPortSelect [*2] |=> jtagRouteEnable;
	endproperty
	a_jtag: assert property (p_jtag) else $error("jtag route missing");
	property p_tristate;
		@(posedge mclk) disable iff (!rst_n) !(sdioTristate == 1'b0 && hsicTristate == 1'b0);
	endproperty
	a_tristate: assert property (p_tristate) else $error("both hosts driven");
	property p_sdioPull;
		@(posedge mclk) disable iff (!rst_n) captured && s_r.strap[2:1] == 2'b11 && !powerDown
			|-> sdioPullEnable && sdioTristate && !hsicTristate;
	endproperty
	a_sdioPull: assert property (p_sdioPull) else $error("sdio pulls off in hsic");
	property p_otp;
		@(posedge mclk) disable iff (!rst_n)
			!otpPowerOn |-> !cardInfoFromOtp && !chipIdFromOtp;
	endproperty
	a_otp: assert property (p_otp) else $error("otp source while off");
	property p_clkReq;
		@(posedge mclk) disable iff (!rst_n)
			powerDown |-> clockRequestPullDown && clockRequestOutEnN;
	endproperty
	a_clkReq: assert property (p_clkReq) else $error("clock request not pulled low");
	property p_regPull;
		@(posedge mclk) disable iff (!rst_n)
			(powerDown || outOfReset) |-> wirelessRegPullDown && bluetoothRegPullDown;
	endproperty
	a_regPull: assert property (p_regPull) else $error("regulator pull-down dropped");
	property p_wake;
		@(posedge mclk) disable iff (!rst_n)
			outOfReset |-> deviceWakePullDown && !deviceWakePullUp && deviceWakeInputEnable;
	endproperty
	a_wake: assert property (p_wake) else $error("wake pin not pulled down");
	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
			captured && $past(captured) |-> $stable(s_r.strap);
	endproperty
	a_hold: assert property (p_hold) else $error("captured straps moved");
endmodule : wlan_strap_config

// [sim/strap_board_model.sv]
`timescale 1ns/1ps
module strap_board_model (
	// clock
	input wire logic mclk,
	// board fitting and host drive
	input wire logic [2:0] strapPullUpFit,
	input wire logic debugPullUpFit,
	input wire logic wakeLevel,
	input wire logic pinsFunctional,
	// pins
	output logic [2:0] hostIfcStrap,
	output logic debugPortSelect,
	output logic deviceWakeIn
);
	logic toggle_r = 1'b0;

	// released pins carry gpio traffic, so a late strap sample sees garbage
	always @(posedge mclk) begin
		toggle_r <= ~toggle_r;
	end

	always_comb begin
		// internal pull-downs give 0 unless a strong pull-up is fitted
		hostIfcStrap = strapPullUpFit;
		if (pinsFunctional) begin
			hostIfcStrap = {toggle_r, ~toggle_r, toggle_r};
		end
		debugPortSelect = debugPullUpFit;
		deviceWakeIn = wakeLevel;
	end
endmodule : strap_board_model

// [sim/tb_wlan_strap_config.sv]
`timescale 1ns/1ps
module tb_wlan_strap_config;
	localparam int CAP = 8;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic extResetN = 1'b0;
	logic [2:0] hostIfcStrap, pullUpFit = 3'h0;
	logic debugPortSelect, deviceWakeIn, jtagFit = 1'b0, wakeLevel = 1'b0;
	logic [1:0] powerState = strap_cfg_pkg::PWR_ACTIVE;
	logic otpProgrammed = 1'b0, clockRequest = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata, wd;
	logic strapPinsFunctional, strapPullEnable, debugSelPullDown, jtagRouteEnable;
	logic [1:0] hostMode;
	logic hostModeUndefined, sdioTristate, hsicTristate, sdioPullEnable, hsicKeeperEnable;
	logic otpPowerOn, cardInfoFromOtp, chipIdFromOtp, op;
	logic clockRequestOut, clockRequestOutEnN, clockRequestPullDown;
	logic wirelessRegPullDown, bluetoothRegPullDown;
	logic deviceWakeInputEnable, deviceWakePullUp, deviceWakePullDown;
	logic rdPend = 1'b0;
	logic [31:0] expQ[$];
	int errors = 0;
	int cmp_count = 0;

	always #50 mclk = ~mclk;

	wlan_strap_config #(.CAPTURE_DELAY(CAP)) wlan_strap_config_i (
		.mclk(mclk), .rst_n(rst_n), .extResetN(extResetN), .hostIfcStrap(hostIfcStrap),
		.debugPortSelect(debugPortSelect), .deviceWakeIn(deviceWakeIn),
		.powerState(powerState), .otpProgrammed(otpProgrammed), .clockRequest(clockRequest),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .strapPinsFunctional(strapPinsFunctional),
		.strapPullEnable(strapPullEnable), .debugSelPullDown(debugSelPullDown),
		.jtagRouteEnable(jtagRouteEnable), .hostMode(hostMode),
		.hostModeUndefined(hostModeUndefined), .sdioTristate(sdioTristate),
		.hsicTristate(hsicTristate), .sdioPullEnable(sdioPullEnable),
		.hsicKeeperEnable(hsicKeeperEnable), .otpPowerOn(otpPowerOn),
		.cardInfoFromOtp(cardInfoFromOtp), .chipIdFromOtp(chipIdFromOtp),
		.clockRequestOut(clockRequestOut), .clockRequestOutEnN(clockRequestOutEnN),
		.clockRequestPullDown(clockRequestPullDown), .wirelessRegPullDown(wirelessRegPullDown),
		.bluetoothRegPullDown(bluetoothRegPullDown),
		.deviceWakeInputEnable(deviceWakeInputEnable), .deviceWakePullUp(deviceWakePullUp),
		.deviceWakePullDown(deviceWakePullDown)
	);

	strap_board_model strap_board_model_i (
		.mclk(mclk), .strapPullUpFit(pullUpFit), .debugPullUpFit(jtagFit),
		.wakeLevel(wakeLevel), .pinsFunctional(strapPinsFunctional),
		.hostIfcStrap(hostIfcStrap), .debugPortSelect(debugPortSelect),
		.deviceWakeIn(deviceWakeIn)
	);

	// ****************************************
	// checking
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// read data stand only in the cycle after the strobe, else zero
	always @(posedge mclk) begin
		if (rdPend) begin
			if (expQ.size() == 0) begin
				errors++;
				$display("mismatch at %0t: read without note", $time);
			end else begin
				check(regRdata, expQ.pop_front());
			end
		end else if (rst_n) begin
			check(regRdata, 32'h0);
		end
		rdPend <= regRead;
	end

	function automatic logic [1:0] expMode(input logic [2:0] c);
		if (!c[2]) return strap_cfg_pkg::HOST_SDIO;
		if (!c[1]) return strap_cfg_pkg::HOST_NONE;
		return c[0] ? strap_cfg_pkg::HOST_HSIC_NO_BOOT : strap_cfg_pkg::HOST_HSIC;
	endfunction : expMode

	// ****************************************
	// drivers
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		expQ.push_back(exp);
		@(posedge mclk);
		regRead <= 1'b0;
	endtask : rd

	task automatic capture(input logic [2:0] code, input logic jt);
		int n;
		logic [1:0] m;
		m = expMode(code);
		@(posedge mclk);
		extResetN <= 1'b0;
		pullUpFit <= code;
		jtagFit <= jt;
		wakeLevel <= code[1];
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		check(strapPinsFunctional, 1'b0);
		check(strapPullEnable, 1'b1);
		check({sdioTristate, hsicTristate}, 2'h3);
		@(posedge mclk);
		extResetN <= 1'b1;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (strapPinsFunctional !== 1'b1 && n < 100);
		if (n >= 100) begin
			errors++;
			$display("mismatch at %0t: capture timeout", $time);
			wrap_up();
		end
		check(n > CAP && n <= CAP + 4, 1'b1);
		check(hostMode, m);
		check(hostModeUndefined, code[2:1] == 2'b10);
		check(sdioTristate, m != strap_cfg_pkg::HOST_SDIO);
		check(hsicTristate, !m[1]);
		check(sdioPullEnable, code[2:1] == 2'b11);
		check(hsicKeeperEnable, 1'b0);
		check(strapPullEnable, 1'b0);
		check({jtagRouteEnable, debugSelPullDown}, {jt, 1'b1});
	endtask : capture

	task automatic padCheck(input logic [5:0] c, input logic [1:0] p, input logic cr);
		logic dn, oor, pp;
		@(posedge mclk);
		powerState <= p;
		clockRequest <= cr;
		otpProgrammed <= op;
		@(negedge mclk);
		dn = p == strap_cfg_pkg::PWR_DOWN;
		oor = p == strap_cfg_pkg::PWR_OUT_OF_RESET;
		pp = c[0] && !dn && !oor;
		check(clockRequestPullDown, dn);
		check(clockRequestOutEnN, dn ? 1'b1 : (pp ? 1'b0 : cr));
		check(clockRequestOut, pp & cr);
		check(wirelessRegPullDown, dn | oor | !c[1]);
		check(bluetoothRegPullDown, dn | oor | !c[2]);
		check(deviceWakeInputEnable, !dn);
		check(deviceWakePullDown, oor | (!dn && c[4:3] == strap_cfg_pkg::WAKE_PULL_DOWN));
		check(deviceWakePullUp, !dn && !oor && c[4:3] == strap_cfg_pkg::WAKE_PULL_UP);
		check(sdioPullEnable, !dn);
		check({otpPowerOn, cardInfoFromOtp, chipIdFromOtp}, {c[5], {2{c[5] & op}}});
	endtask : padCheck

	// ****************************************
	// tests
	// ****************************************
	initial begin
		void'($urandom(58));
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			capture(3'(c), c[0]);
			rd(strap_cfg_pkg::STATUS_OFFSET, {22'h0, wakeLevel, 2'h0, c[0],
				expMode(3'(c)), 3'(c), 1'b1});
			repeat (6) @(posedge mclk);
			@(negedge mclk);
			check(hostMode, expMode(3'(c)));
		end
		$display("test strap capture and decode done");
		for (int k = 0; k < 6; k++) begin
			wd = $urandom;
			wd[4:3] = 2'(k % 3);
			op = 1'($urandom);
			wr(strap_cfg_pkg::CTRL_OFFSET, wd);
			rd(strap_cfg_pkg::CTRL_OFFSET, {26'h0, wd[5:0]});
			for (int p = 0; p < 4; p++) begin
				padCheck(wd[5:0], 2'(p), 1'b0);
				padCheck(wd[5:0], 2'(p), 1'b1);
			end
			@(posedge mclk);
			powerState <= strap_cfg_pkg::PWR_ACTIVE;
			rd(strap_cfg_pkg::STATUS_OFFSET, {22'h0, wakeLevel, wd[5] & op, wd[5], 1'b1,
				2'h3, 3'h7, 1'b1});
		end
		$display("test pad control done");
		wr(8'h08, 32'hffffffff);
		wr(strap_cfg_pkg::STATUS_OFFSET, 32'h0);
		rd(8'h08, 32'h0);
		rd(strap_cfg_pkg::CTRL_OFFSET, {26'h0, wd[5:0]});
		rd(strap_cfg_pkg::STATUS_OFFSET, {22'h0, wakeLevel, wd[5] & op, wd[5], 1'b1,
			2'h3, 3'h7, 1'b1});
		repeat (3) @(posedge mclk);
		$display("test register refusals done");
		wrap_up();
	end
endmodule : tb_wlan_strap_config
